// *** flash_port_pkg.sv ***
// Purpose: Shared constants and types for the serial flash program port.
// Assumes: Crystal clock at 40 MHz; host obeys the serial wait times.
// Notes: Timing counts are derived from the printed times and the rate.
package flash_port_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_STEP = 3'h1;
  localparam logic [BIT_CNT_W-1:0] ERR_FLAG_IDX = 3'h0;

  // Command codes
  localparam logic [BYTE_W-1:0] CMD_READ = 8'h00;
  localparam logic [BYTE_W-1:0] CMD_PROGRAM = 8'h40;
  localparam logic [BYTE_W-1:0] CMD_PROG_VERIFY = 8'hC0;
  localparam logic [BYTE_W-1:0] CMD_ERASE = 8'h20;
  localparam logic [BYTE_W-1:0] CMD_ERASE_VERIFY = 8'hA0;
  localparam logic [BYTE_W-1:0] CMD_ERROR_CHECK = 8'h80;

  // Internal operation timing
  localparam int CLK_MHZ = 40;
  localparam real PROG_TIME_US = 10.0;
  localparam real ERASE_TIME_MS = 9.5;
  // Longest times round down
  localparam int PROG_CYCLES = int'($floor(PROG_TIME_US * CLK_MHZ));
  localparam int ERASE_CYCLES =
    int'($floor(ERASE_TIME_MS * 1000.0 * CLK_MHZ));
  localparam int TIMER_W = 19;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_ADDR_LO,
    LS_ADDR_HI,
    LS_DATA,
    LS_ERASE2,
    LS_OUT,
    LS_HALT
  } link_state_e;

endpackage

// *** op_timer.sv ***
// Purpose: Busy timer for program and erase operations.
// Assumes: Start pulses are one clock wide and never overlap a busy period.
// Notes: A start while busy restarts the count; the host never does that.
`timescale 1ns/1ps
module op_timer #(
  parameter int PROG_CYCLES = 400,
  parameter int ERASE_CYCLES = 380000,
  parameter int CNT_W = 19
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic start_program,
  input wire logic start_erase,
  output logic busy
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    if (start_program) begin
      cnt_nxt = CNT_W'(PROG_CYCLES - 1);
      busy_nxt = 1'b1;
    end else if (start_erase) begin
      cnt_nxt = CNT_W'(ERASE_CYCLES - 1);
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      if (cnt_r == '0) begin
        busy_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;

endmodule

// *** serial_flash_program_port.sv ***
// Purpose: Serial command port of the flash array in serial program mode.
// Assumes: Host keeps serial clock and wait times; memory answers next clock.
// Notes: Command decode runs on the serial clock, operations on the crystal.
`timescale 1ns/1ps
module serial_flash_program_port
  import flash_port_pkg::*;
#(
  parameter int PROG_TIME_CYCLES = PROG_CYCLES,
  parameter int ERASE_TIME_CYCLES = ERASE_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic serial_clock,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_drive_n,
  input wire logic output_strobe_n,
  input wire logic program_supply_low_level,
  output logic busy,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_read,
  input wire logic [BYTE_W-1:0] mem_rdata,
  output logic mem_program,
  output logic [BYTE_W-1:0] mem_wdata,
  output logic mem_erase
);

  // Crystal-domain synchronisers and strobes
  logic supply_s1_r;
  logic supply_s2_r;
  logic strobe_s1_r;
  logic strobe_s2_r;
  logic strobe_prev_r;
  logic pend_s1_r;
  logic pend_s2_r;
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_prev_r;
  logic [ADDR_W-1:0] mem_addr_r;
  logic [ADDR_W-1:0] mem_addr_nxt;
  logic mem_read_r;
  logic mem_read_nxt;
  logic [BYTE_W-1:0] latch_r;
  logic [BYTE_W-1:0] latch_nxt;
  logic [BYTE_W-1:0] wdata_r;
  logic [BYTE_W-1:0] wdata_nxt;
  logic prog_start_r;
  logic prog_start_nxt;
  logic erase_start_r;
  logic erase_start_nxt;
  logic strobe_fall;
  logic op_event;

  // Serial-domain state
  logic link_rst_n;
  link_state_e state_r;
  link_state_e state_nxt;
  logic [BYTE_W-1:0] rx_shift_r;
  logic [BYTE_W-1:0] rx_shift_nxt;
  logic [BIT_CNT_W-1:0] rx_cnt_r;
  logic [BIT_CNT_W-1:0] rx_cnt_nxt;
  logic [BIT_CNT_W-1:0] out_cnt_r;
  logic [BIT_CNT_W-1:0] out_cnt_nxt;
  logic [BYTE_W-1:0] cmd_r;
  logic [BYTE_W-1:0] cmd_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [BYTE_W-1:0] data_r;
  logic [BYTE_W-1:0] data_nxt;
  logic op_tgl_r;
  logic op_tgl_nxt;
  logic read_pend_r;
  logic read_pend_nxt;
  logic err_r;
  logic err_nxt;
  logic err_set;
  logic err_clr;
  logic [BYTE_W-1:0] rx_byte;
  logic byte_done;
  logic sda_out_r;
  logic sda_out_nxt;
  logic drive_on_r;
  logic drive_on_nxt;

  // Crystal domain
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      supply_s1_r <= 1'b1;
      supply_s2_r <= 1'b1;
      strobe_s1_r <= 1'b1;
      strobe_s2_r <= 1'b1;
      strobe_prev_r <= 1'b1;
      pend_s1_r <= 1'b0;
      pend_s2_r <= 1'b0;
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_prev_r <= 1'b0;
    end else begin
      supply_s1_r <= program_supply_low_level;
      supply_s2_r <= supply_s1_r;
      strobe_s1_r <= output_strobe_n;
      strobe_s2_r <= strobe_s1_r;
      strobe_prev_r <= strobe_s2_r;
      pend_s1_r <= read_pend_r;
      pend_s2_r <= pend_s1_r;
      tgl_s1_r <= op_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_prev_r <= tgl_s2_r;
    end
  end

  assign strobe_fall = strobe_prev_r & ~strobe_s2_r;
  // Toggle handshake; command fields are held still until next transfer
  assign op_event = tgl_s2_r ^ tgl_prev_r;

  always_comb begin
    mem_addr_nxt = mem_addr_r;
    wdata_nxt = wdata_r;
    latch_nxt = latch_r;
    mem_read_nxt = strobe_fall & pend_s2_r;
    if (mem_read_nxt || op_event) begin
      mem_addr_nxt = addr_r;
    end
    if (op_event) begin
      wdata_nxt = data_r;
    end
    if (mem_read_r) begin
      latch_nxt = mem_rdata;
    end
    prog_start_nxt = op_event & (cmd_r == CMD_PROGRAM);
    erase_start_nxt = op_event & (cmd_r == CMD_ERASE);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mem_addr_r <= '0;
      mem_read_r <= 1'b0;
      latch_r <= '0;
      wdata_r <= '0;
      prog_start_r <= 1'b0;
      erase_start_r <= 1'b0;
    end else begin
      mem_addr_r <= mem_addr_nxt;
      mem_read_r <= mem_read_nxt;
      latch_r <= latch_nxt;
      wdata_r <= wdata_nxt;
      prog_start_r <= prog_start_nxt;
      erase_start_r <= erase_start_nxt;
    end
  end

  op_timer #(
    .PROG_CYCLES(PROG_TIME_CYCLES),
    .ERASE_CYCLES(ERASE_TIME_CYCLES),
    .CNT_W(TIMER_W)
  ) u_timer (
    .clock(clock),
    .resetn(resetn),
    .start_program(prog_start_r),
    .start_erase(erase_start_r),
    .busy(busy)
  );

  assign mem_addr = mem_addr_r;
  assign mem_read = mem_read_r;
  assign mem_wdata = wdata_r;
  assign mem_program = prog_start_r;
  assign mem_erase = erase_start_r;

  // Serial domain; the dropped supply resets the port, not the flag
  assign link_rst_n = resetn & ~supply_s2_r;

  assign rx_byte = {sda_in, rx_shift_r[BYTE_W-1:1]};
  assign byte_done = (rx_cnt_r == LAST_BIT);

  always_comb begin
    state_nxt = state_r;
    rx_shift_nxt = rx_byte;
    rx_cnt_nxt = rx_cnt_r + BIT_STEP;
    out_cnt_nxt = out_cnt_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    op_tgl_nxt = op_tgl_r;
    err_set = 1'b0;
    err_clr = 1'b0;
    unique case (state_r)
      LS_IDLE: begin
        if (byte_done) begin
          cmd_nxt = rx_byte;
          unique case (rx_byte)
            CMD_READ, CMD_PROGRAM, CMD_ERASE_VERIFY:
              state_nxt = LS_ADDR_LO;
            CMD_PROG_VERIFY:
              state_nxt = LS_OUT;
            CMD_ERASE:
              state_nxt = LS_ERASE2;
            CMD_ERROR_CHECK:
              state_nxt = LS_OUT;
            default: begin
              state_nxt = LS_HALT;
              err_set = 1'b1;
            end
          endcase
        end
      end
      LS_ADDR_LO: begin
        if (byte_done) begin
          addr_nxt[BYTE_W-1:0] = rx_byte;
          state_nxt = LS_ADDR_HI;
        end
      end
      LS_ADDR_HI: begin
        if (byte_done) begin
          addr_nxt[ADDR_W-1:BYTE_W] = rx_byte;
          state_nxt = (cmd_r == CMD_PROGRAM) ? LS_DATA : LS_OUT;
        end
      end
      LS_DATA: begin
        if (byte_done) begin
          data_nxt = rx_byte;
          op_tgl_nxt = ~op_tgl_r;
          state_nxt = LS_IDLE;
        end
      end
      LS_ERASE2: begin
        if (byte_done) begin
          if (rx_byte == CMD_ERASE) begin
            op_tgl_nxt = ~op_tgl_r;
            state_nxt = LS_IDLE;
          end else begin
            state_nxt = LS_HALT;
            err_set = 1'b1;
          end
        end
      end
      LS_OUT: begin
        // Host drives no input bits while the device shifts out
        rx_shift_nxt = rx_shift_r;
        rx_cnt_nxt = rx_cnt_r;
        out_cnt_nxt = out_cnt_r + BIT_STEP;
        if (out_cnt_r == LAST_BIT) begin
          state_nxt = LS_IDLE;
          err_clr = (cmd_r == CMD_ERROR_CHECK);
        end
      end
      LS_HALT: begin
        // Deaf until the supply is dropped and mode re-entered
        rx_shift_nxt = rx_shift_r;
        rx_cnt_nxt = rx_cnt_r;
      end
    endcase
    read_pend_nxt = (state_nxt == LS_OUT) && (cmd_nxt != CMD_ERROR_CHECK);
    // Set wins over clear
    err_nxt = err_set ? 1'b1 : (err_clr ? 1'b0 : err_r);
  end

  always_ff @(posedge serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_r <= LS_IDLE;
      rx_shift_r <= '0;
      rx_cnt_r <= '0;
      out_cnt_r <= '0;
      cmd_r <= CMD_READ;
      addr_r <= '0;
      data_r <= '0;
      op_tgl_r <= 1'b0;
      read_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      out_cnt_r <= out_cnt_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      op_tgl_r <= op_tgl_nxt;
      read_pend_r <= read_pend_nxt;
    end
  end

  // Flag survives mode re-entry; only power-on reset and an error check read clear it
  always_ff @(posedge serial_clock or negedge resetn) begin
    if (!resetn) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
    end
  end

  // Latch is quasi-static here: host waits after strobe before clocking
  always_comb begin
    if (cmd_r == CMD_ERROR_CHECK) begin
      sda_out_nxt = (out_cnt_r == ERR_FLAG_IDX) ? err_r : 1'b0;
    end else begin
      sda_out_nxt = latch_r[out_cnt_r];
    end
    drive_on_nxt = (state_r == LS_OUT);
  end

  always_ff @(negedge serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_out_r <= 1'b1;
      drive_on_r <= 1'b0;
    end else begin
      sda_out_r <= sda_out_nxt;
      drive_on_r <= drive_on_nxt;
    end
  end

  assign sda_out = sda_out_r;
  // Released at the rising edge that samples the last output bit
  assign sda_drive_n = ~(drive_on_r & (state_r == LS_OUT));

endmodule

// *** serial_flash_program_port_checker.sv ***
// Purpose: Port-level timing checks for the serial flash program port.
// Assumes: Bench sets the short program and erase counts.
// Notes: Busy length is counted here, tolerance two cycles.
`timescale 1ns/1ps
module serial_flash_program_port_checker
  import flash_port_pkg::*;
#(
  parameter int PROG_TIME_CYCLES = 10,
  parameter int ERASE_TIME_CYCLES = 50
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic serial_clock,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_drive_n,
  input wire logic output_strobe_n,
  input wire logic program_supply_low_level,
  input wire logic busy,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_read,
  input wire logic [BYTE_W-1:0] mem_rdata,
  input wire logic mem_program,
  input wire logic [BYTE_W-1:0] mem_wdata,
  input wire logic mem_erase
);
  localparam int P_LO = PROG_TIME_CYCLES - 2;
  localparam int P_HI = PROG_TIME_CYCLES + 2;
  localparam int E_LO = ERASE_TIME_CYCLES - 2;
  localparam int E_HI = ERASE_TIME_CYCLES + 2;
  int cnt_r;
  int cnt_nxt;
  always_comb cnt_nxt = busy ? cnt_r + 1 : 0;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) cnt_r <= 0;
    else cnt_r <= cnt_nxt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_prog_pulse; mem_program |=> !mem_program; endproperty
  property p_erase_pulse; mem_erase |=> !mem_erase; endproperty
  property p_read_strobe;
    mem_read |-> !$past(output_strobe_n, 2) ##1 !mem_read;
  endproperty
  property p_busy_cause;
    $rose(busy) |-> mem_program || mem_erase
      || $past(mem_program || mem_erase);
  endproperty
  property p_erase_hold; mem_erase |=> busy [*8]; endproperty
  property p_prog_hold; mem_program |=> busy [*3]; endproperty
  property p_busy_len;
    $fell(busy) |-> (cnt_r >= P_LO && cnt_r <= P_HI)
      || (cnt_r >= E_LO && cnt_r <= E_HI);
  endproperty
  property p_port_reset;
    program_supply_low_level [*5] |-> sda_drive_n;
  endproperty
  property p_drive_idle; busy |-> sda_drive_n; endproperty
  a_prog_pulse: assert property (p_prog_pulse)
    else $error("program pulse too long");
  a_erase_pulse: assert property (p_erase_pulse)
    else $error("erase pulse too long");
  a_read_strobe: assert property (p_read_strobe)
    else $error("array read without strobe");
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without operation start");
  a_erase_hold: assert property (p_erase_hold)
    else $error("busy dropped early in erase");
  a_prog_hold: assert property (p_prog_hold)
    else $error("busy dropped early in program");
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  a_port_reset: assert property (p_port_reset)
    else $error("data line driven in port reset");
  a_drive_idle: assert property (p_drive_idle)
    else $error("data line driven while busy");
  c_erase: cover property (mem_erase);
  c_prog: cover property (mem_program);
  c_read: cover property (mem_read);
  c_supply: cover property ($rose(program_supply_low_level));
endmodule

bind serial_flash_program_port serial_flash_program_port_checker #(
  .PROG_TIME_CYCLES(PROG_TIME_CYCLES),
  .ERASE_TIME_CYCLES(ERASE_TIME_CYCLES)
) u_chk (
  .clock(clock), .resetn(resetn), .serial_clock(serial_clock),
  .sda_in(sda_in), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
  .output_strobe_n(output_strobe_n),
  .program_supply_low_level(program_supply_low_level),
  .busy(busy), .mem_addr(mem_addr), .mem_read(mem_read),
  .mem_rdata(mem_rdata), .mem_program(mem_program),
  .mem_wdata(mem_wdata), .mem_erase(mem_erase)
);

// *** flash_host_model.sv ***
// Purpose: External programmer driving serial clock, data and strobe.
// Assumes: Serial clock idles high and stands still between bytes.
// Notes: Released line shows the inverse of its last level.
`timescale 1ns/1ps
module flash_host_model (
  output logic serial_clock,
  output logic output_strobe_n,
  output logic sda_in,
  input wire logic sda_out,
  input wire logic sda_drive_n
);
  logic bit_r = 1'b1;
  logic host_en = 1'b1;
  logic last_r = 1'b1;
  initial serial_clock = 1'b1;
  initial output_strobe_n = 1'b1;
  always_comb begin
    if (!sda_drive_n) sda_in = sda_out;
    else if (host_en) sda_in = bit_r;
    else sda_in = ~last_r;
  end
  always @(negedge serial_clock) last_r <= sda_in;
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      serial_clock = 1'b0;
      bit_r = b[i];
      // Far shorter phases than a real host; port has no period floor
      #3;
      serial_clock = 1'b1;
      #3;
    end
    #600;
  endtask
  task automatic recv(output logic [7:0] b);
    host_en = 1'b0;
    for (int i = 0; i < 8; i++) begin
      serial_clock = 1'b0;
      #3;
      b[i] = sda_in;
      serial_clock = 1'b1;
      #3;
    end
    host_en = 1'b1;
    #600;
  endtask
  task automatic strobe();
    output_strobe_n = 1'b0;
    #500;
    output_strobe_n = 1'b1;
    #600;
  endtask
endmodule

// *** serial_flash_program_port_tb.sv ***
// Purpose: Self-checking bench for the serial flash program port.
// Assumes: Array is modelled here on the low address byte only.
// Notes: Program ANDs into the cell, erase sets every cell to ones.
`timescale 1ns/1ps
module serial_flash_program_port_tb;
  import flash_port_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic program_supply_low_level = 1'b0;
  logic serial_clock, sda_in, sda_out, sda_drive_n, output_strobe_n;
  logic busy, mem_read, mem_program, mem_erase, drove;
  logic [ADDR_W-1:0] mem_addr, a;
  logic [BYTE_W-1:0] mem_rdata, mem_wdata, got, d;
  logic [BYTE_W-1:0] mem [0:255];
  int errors = 0;
  int tests_run = 0;
  int seed = 32'h0386e032;
  initial forever #12.5 clock = ~clock;
  assign mem_rdata = mem[mem_addr[7:0]];
  always @(posedge clock) begin
    // High address byte is not modelled, so check it at the array
    if (mem_read || mem_program) chk(mem_addr[15:8], a[15:8]);
    if (mem_program) mem[mem_addr[7:0]] <= mem[mem_addr[7:0]] & mem_wdata;
    if (mem_erase) for (int i = 0; i < 256; i++) mem[i] <= 8'hFF;
  end
  always @(negedge sda_drive_n) drove = 1'b1;
  serial_flash_program_port #(
    .PROG_TIME_CYCLES(10), .ERASE_TIME_CYCLES(50)
  ) u_dut (
    .clock(clock), .resetn(resetn), .serial_clock(serial_clock),
    .sda_in(sda_in), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
    .output_strobe_n(output_strobe_n),
    .program_supply_low_level(program_supply_low_level),
    .busy(busy), .mem_addr(mem_addr), .mem_read(mem_read),
    .mem_rdata(mem_rdata), .mem_program(mem_program),
    .mem_wdata(mem_wdata), .mem_erase(mem_erase)
  );
  flash_host_model u_host (
    .serial_clock(serial_clock), .output_strobe_n(output_strobe_n),
    .sda_in(sda_in), .sda_out(sda_out), .sda_drive_n(sda_drive_n)
  );
  function automatic logic [7:0] err_byte(input logic f);
    return {7'h00, f};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] b);
    u_host.send(c);
    if (c !== CMD_PROG_VERIFY) begin
      u_host.send(a[7:0]);
      u_host.send(a[15:8]);
    end
    u_host.strobe();
    u_host.recv(b);
  endtask
  task automatic errchk(output logic [7:0] b);
    u_host.send(CMD_ERROR_CHECK);
    u_host.recv(b);
  endtask
  task automatic supply_pulse();
    @(posedge clock) #2 program_supply_low_level = 1'b1;
    repeat (6) @(posedge clock);
    #2 program_supply_low_level = 1'b0;
    repeat (4) @(posedge clock);
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
    repeat (6) @(posedge clock);
    #2 resetn = 1'b1;
    repeat (4) @(posedge clock);
    errchk(got);
    chk(got, err_byte(1'b0));
    for (int i = 0; i < 4; i++) begin
      a = 16'($random(seed));
      a[7:0] = 8'(i);
      d = (i == 3) ? 8'h00 : 8'($random(seed));
      u_host.send(CMD_PROGRAM);
      u_host.send(a[7:0]);
      u_host.send(a[15:8]);
      u_host.send(d);
      #6000;
      rd(CMD_PROG_VERIFY, got);
      chk(got, d);
      rd(CMD_READ, got);
      chk(got, d);
    end
    got = 8'h00;
    for (int k = 0; k < 3 && got !== 8'hFF; k++) begin
      u_host.send(CMD_ERASE);
      u_host.send(CMD_ERASE);
      chk({7'h00, busy}, 8'h01);
      for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clock);
      chk({7'h00, busy}, 8'h00);
      #600;
      rd(CMD_ERASE_VERIFY, got);
    end
    chk(got, 8'hFF);
    for (int j = 0; j < 2; j++) begin
      u_host.send(j == 0 ? 8'h55 : CMD_ERASE);
      if (j == 1) u_host.send(8'h21);
      drove = 1'b0;
      errchk(got);
      chk({7'h00, drove}, 8'h00);
      supply_pulse();
      errchk(got);
      chk(got, err_byte(1'b1));
      errchk(got);
      chk(got, err_byte(1'b0));
    end
    results();
  end
  initial begin
    #500000;
    errors++;
    results();
  end
endmodule
